// ---- verilog/anp_mdio_slave.sv ----
// serial management frame slave: decodes reads and writes
`timescale 1ns/100ps
`default_nettype none
`include "anp_cfg.svh"
module anp_mdio_slave (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // management pins
  input wire logic [4:0] phy_addr_in,
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_out,
  // register side
  input wire logic [15:0] rd_data_in,
  output anp_pkg::anp_mgmt_s mgmt_out
);
  anp_pkg::anp_mdio_e state_q;
  logic mdc_q;
  logic [5:0] cnt_q;
  logic [15:0] sh_q;
  logic [4:0] idx_q;
  logic rd_q;
  logic rd_stb_q;
  logic wr_stb_q;
  logic mdio_o_q;
  logic oe_q;
  wire mdc_rise;
  wire [12:0] hdr;
  wire hdr_ok;
  wire hdr_rd;
  wire hdr_wr;

  assign mdc_rise = mdc_in & ~mdc_q;
  assign hdr = {sh_q[11:0], mdio_in};
  assign hdr_ok = hdr[12] & (hdr[9:5] == phy_addr_in);
  assign hdr_rd = hdr_ok & (hdr[11:10] == `ANP_OP_READ);
  assign hdr_wr = hdr_ok & (hdr[11:10] == `ANP_OP_WRITE);
  assign mdio_out = mdio_o_q;
  assign mdio_oe_out = oe_q;
  assign mgmt_out = '{rd: rd_stb_q, wr: wr_stb_q, idx: idx_q, data: sh_q};

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_q <= anp_pkg::ST_PRE;
      // held high so a high mdc at release is no rise
      mdc_q <= 1'b1;
      cnt_q <= 6'h00;
      sh_q <= 16'h0000;
      idx_q <= 5'h00;
      rd_q <= 1'b0;
      rd_stb_q <= 1'b0;
      wr_stb_q <= 1'b0;
      mdio_o_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      mdc_q <= mdc_in;
      rd_stb_q <= 1'b0;
      wr_stb_q <= 1'b0;
      if (rd_stb_q) begin
        sh_q <= rd_data_in;
      end
      if (mdc_rise) begin
        case (state_q)
          anp_pkg::ST_PRE: begin
            if (mdio_in) begin
              if (cnt_q != `ANP_PRE_ONES) begin
                cnt_q <= cnt_q + 6'h01;
              end
            end else if (cnt_q == `ANP_PRE_ONES) begin
              state_q <= anp_pkg::ST_HDR;
              cnt_q <= 6'h00;
            end else begin
              cnt_q <= 6'h00;
            end
          end
          anp_pkg::ST_HDR: begin
            sh_q <= {sh_q[14:0], mdio_in};
            if (cnt_q == `ANP_HDR_LAST) begin
              cnt_q <= 6'h00;
              idx_q <= hdr[4:0];
              rd_q <= hdr_rd;
              rd_stb_q <= hdr_rd;
              state_q <= (hdr_rd | hdr_wr) ? anp_pkg::ST_TA
                                           : anp_pkg::ST_PRE;
            end else begin
              cnt_q <= cnt_q + 6'h01;
            end
          end
          anp_pkg::ST_TA: begin
            if (cnt_q == 6'h00) begin
              cnt_q <= 6'h01;
              oe_q <= rd_q;
              mdio_o_q <= 1'b0;
            end else begin
              cnt_q <= 6'h00;
              if (rd_q) begin
                mdio_o_q <= sh_q[15];
                sh_q <= {sh_q[14:0], 1'b0};
                state_q <= anp_pkg::ST_RDAT;
              end else begin
                state_q <= anp_pkg::ST_WDAT;
              end
            end
          end
          anp_pkg::ST_RDAT: begin
            if (cnt_q == `ANP_DATA_LAST) begin
              oe_q <= 1'b0;
              mdio_o_q <= 1'b0;
              cnt_q <= 6'h00;
              state_q <= anp_pkg::ST_PRE;
            end else begin
              mdio_o_q <= sh_q[15];
              sh_q <= {sh_q[14:0], 1'b0};
              cnt_q <= cnt_q + 6'h01;
            end
          end
          anp_pkg::ST_WDAT: begin
            sh_q <= {sh_q[14:0], mdio_in};
            if (cnt_q == `ANP_DATA_LAST) begin
              wr_stb_q <= 1'b1;
              cnt_q <= 6'h00;
              state_q <= anp_pkg::ST_PRE;
            end else begin
              cnt_q <= cnt_q + 6'h01;
            end
          end
          default: begin
            state_q <= anp_pkg::ST_PRE;
            cnt_q <= 6'h00;
            oe_q <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // anp_mdio_slave
`default_nettype wire

// ---- verilog/anp_cfg.svh ----
// register indices, field positions, reset values and frame counts
`ifndef ANP_CFG_SVH
`define ANP_CFG_SVH

`define ANP_IDX_LP_BASE 5'h05
`define ANP_IDX_EXP 5'h06
`define ANP_IDX_NP_TX 5'h07
`define ANP_IDX_NP_RX 5'h08

`define ANP_EXP_LP_AN_ABLE 0
`define ANP_EXP_PAGE_RX 1
`define ANP_EXP_NP_ABLE 2
`define ANP_EXP_LP_NP_ABLE 3
`define ANP_EXP_PD_FAULT 4
`define ANP_EXP_NP_LOC 5
`define ANP_EXP_NP_LOC_ABLE 6

`define ANP_NP_TX_RST 16'h2001
`define ANP_NP_TX_WMASK 16'hB7FF
`define ANP_NP_RX_RST 16'h0000
`define ANP_EXP_RSVD 9'h000

`define ANP_PRE_ONES 6'h20
`define ANP_HDR_LAST 6'h0C
`define ANP_DATA_LAST 6'h0F

`define ANP_OP_READ 2'h2
`define ANP_OP_WRITE 2'h1

`endif

// ---- verilog/anp_pkg.sv ----
// types shared by the next page register block
`default_nettype none
package anp_pkg;

  typedef struct packed {
    logic next_page;
    logic ack;
    logic msg_page;
    logic ack2;
    logic toggle;
    logic [10:0] code;
  } anp_page_s;

  typedef struct packed {
    logic pd_fault;
    logic page_rx;
    logic lp_np_able;
    logic lp_an_able;
    logic tx_toggle;
    anp_page_s rx_page;
    logic [15:0] lp_base;
  } anp_an_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] idx;
    logic [15:0] data;
  } anp_mgmt_s;

  typedef enum logic [4:0] {
    ST_PRE = 5'h01,
    ST_HDR = 5'h02,
    ST_TA = 5'h04,
    ST_RDAT = 5'h08,
    ST_WDAT = 5'h10
  } anp_mdio_e;

endpackage
`default_nettype wire

// ---- verilog/anp_lh_flag.sv ----
// latched-high status flag, set wins over the read clear
`timescale 1ns/100ps
`default_nettype none
module anp_lh_flag (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // event and clear
  input wire logic set_in,
  input wire logic clr_in,
  // flag
  output logic flag_out
);
  logic flag_q;
  logic flag_d;

  assign flag_d = set_in | (flag_q & ~clr_in);
  assign flag_out = flag_q;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule // anp_lh_flag
`default_nettype wire

// ---- verilog/anp_regs.sv ----
// auto-negotiation expansion and next page registers behind the mgmt pins
`timescale 1ns/100ps
`default_nettype none
`include "anp_cfg.svh"
module anp_regs (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // management pins
  input wire logic [4:0] phy_addr_in,
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_out,
  // auto-negotiation engine side
  input wire anp_pkg::anp_an_s an_in,
  output anp_pkg::anp_page_s np_tx_out,
  output logic np_tx_loaded_out
);
  anp_pkg::anp_mgmt_s mgmt;
  logic [15:0] np_tx_q;
  logic [15:0] np_tx_d;
  anp_pkg::anp_page_s np_rx_q;
  logic [1:0] lh_flags;
  wire [1:0] lh_set;
  wire rd_exp;
  wire wr_np_tx;
  wire [15:0] exp_val;
  wire [15:0] np_tx_val;
  wire [15:0] rd_data;

  function automatic logic hit(input logic [4:0] idx,
                               input logic [4:0] want);
    hit = (idx == want);
  endfunction

  anp_mdio_slave u_mdio (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .phy_addr_in(phy_addr_in),
    .mdc_in(mdc_in),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_oe_out(mdio_oe_out),
    .rd_data_in(rd_data),
    .mgmt_out(mgmt)
  );

  // latched-high flags, cleared by a read of the expansion register
  assign rd_exp = mgmt.rd & hit(mgmt.idx, `ANP_IDX_EXP);
  assign lh_set = {an_in.pd_fault, an_in.page_rx};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_lh
      anp_lh_flag u_flag (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .set_in(lh_set[gi]),
        .clr_in(rd_exp),
        .flag_out(lh_flags[gi])
      );
    end
  endgenerate

  // expansion register image
  assign exp_val = {`ANP_EXP_RSVD,
                    1'b1,
                    1'b1,
                    lh_flags[1],
                    an_in.lp_np_able,
                    1'b1,
                    lh_flags[0],
                    an_in.lp_an_able};

  // transmit page: only writable bits take write data
  assign wr_np_tx = mgmt.wr & hit(mgmt.idx, `ANP_IDX_NP_TX);
  assign np_tx_d = (mgmt.data & `ANP_NP_TX_WMASK)
                 | (np_tx_q & ~`ANP_NP_TX_WMASK);
  assign np_tx_val = {np_tx_q[15:12], an_in.tx_toggle, np_tx_q[10:0]};
  assign np_tx_out = anp_pkg::anp_page_s'(np_tx_val);

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      np_tx_q <= `ANP_NP_TX_RST;
      np_tx_loaded_out <= 1'b0;
    end else begin
      np_tx_loaded_out <= wr_np_tx;
      if (wr_np_tx) begin
        np_tx_q <= np_tx_d;
      end
    end
  end

  // receive page captured from each page the partner delivers
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      np_rx_q <= anp_pkg::anp_page_s'(`ANP_NP_RX_RST);
    end else if (an_in.page_rx) begin
      np_rx_q <= an_in.rx_page;
    end
  end

  // read selection, unmapped indices read zero
  assign rd_data = hit(mgmt.idx, `ANP_IDX_LP_BASE) ? an_in.lp_base :
                   hit(mgmt.idx, `ANP_IDX_EXP) ? exp_val :
                   hit(mgmt.idx, `ANP_IDX_NP_TX) ? np_tx_val :
                   hit(mgmt.idx, `ANP_IDX_NP_RX) ? np_rx_q :
                   16'h0000;
endmodule // anp_regs
`default_nettype wire

// ---- sim/anp_regs_props.sv ----
// port assertions for the next page register block
`timescale 1ns/100ps
`default_nettype none
module anp_regs_props (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // management pins
  input wire logic [4:0] phy_addr_in,
  input wire logic mdc_in,
  input wire logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe_out,
  // engine side
  input wire anp_pkg::anp_an_s an_in,
  input wire anp_pkg::anp_page_s np_tx_out,
  input wire logic np_tx_loaded_out
);
  logic mdc_q;
  logic [4:0] cnt_q;
  wire logic rise = mdc_in & ~mdc_q;
  wire logic [13:0] st = {np_tx_out.next_page, np_tx_out.msg_page,
    np_tx_out.ack2, np_tx_out.code};
  // counts mdc rises while the device drives
  always_ff @(posedge clock_in) begin
    mdc_q <= mdc_in;
    cnt_q <= mdio_oe_out ? cnt_q + {4'h0, rise} : 5'h00;
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sequence oe_stand;
    mdio_oe_out [*8];
  endsequence
  chk_tog_follow: assert property (
    np_tx_out.toggle == an_in.tx_toggle) else $error("toggle mismatch");
  chk_rsvd_zero: assert property (
    np_tx_out.ack == 1'h0) else $error("reserved bit set");
  chk_load_pulse: assert property (
    np_tx_loaded_out |=> !np_tx_loaded_out) else $error("load too long");
  chk_load_cause: assert property (
    $changed(st) |-> np_tx_loaded_out) else $error("store without write");
  chk_ta_low: assert property (
    $rose(mdio_oe_out) |-> !mdio_out ##0 oe_stand) else $error("bad ta");
  chk_oe_len: assert property (
    $fell(mdio_oe_out) |-> cnt_q == 5'h11) else $error("drive length");
  chk_out_step: assert property (
    $changed(mdio_out) |-> $past(rise)) else $error("data off step");
  chk_oe_step: assert property (
    $rose(mdio_oe_out) |-> $past(rise)) else $error("enable off step");
endmodule // anp_regs_props
bind anp_regs anp_regs_props anp_regs_props_i (.clock_in, .rst_n_in,
  .phy_addr_in, .mdc_in, .mdio_in, .mdio_out, .mdio_oe_out, .an_in,
  .np_tx_out, .np_tx_loaded_out);
`default_nettype wire

// ---- sim/anp_mdio_host.sv ----
// management host model that runs whole frames
`timescale 1ns/100ps
`default_nettype none
module anp_mdio_host (
  // clock
  input wire logic clock_in,
  // device pins
  input wire logic mdio_out,
  input wire logic mdio_oe_out,
  output logic mdc_out,
  output logic mdio_to_dev_out
);
  logic drv_q = 1'h0;
  logic bit_q = 1'h1;
  initial mdc_out = 1'h0;
  // released line rests on its pull-up
  assign mdio_to_dev_out = mdio_oe_out ? mdio_out : (drv_q ? bit_q : 1'h1);
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
    input logic [4:0] idx, input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    f = {32'hFFFFFFFF, 2'h1, op, phy, idx, 2'h2, wd};
    for (int i = 63; i >= 0; i--) begin
      @(posedge clock_in);
      mdc_out <= 1'h0;
      drv_q <= (op != 2'h2) || (i > 17);
      bit_q <= f[i];
      repeat (2) @(posedge clock_in);
      // device bits stand from the previous rise up to this one
      if (i < 16) rd[i] = mdio_to_dev_out;
      mdc_out <= 1'h1;
      repeat (3) @(posedge clock_in);
    end
    @(posedge clock_in);
    drv_q <= 1'h0;
  endtask
endmodule // anp_mdio_host
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench for the next page register block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clock_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic [4:0] phy_addr = 5'h03;
  logic mdc, mdio_d, mdio_out, mdio_oe, np_ld;
  anp_pkg::anp_an_s an = '0;
  anp_pkg::anp_page_s np_tx;
  logic [15:0] tx_m = 16'h2001;
  logic [15:0] rx_m = 16'h0000;
  logic [15:0] rd, v;
  logic pr_m = 1'h0;
  logic pd_m = 1'h0;
  int n_errors = 0;
  int check_count = 0;
  anp_regs anp_regs_i (.clock_in, .rst_n_in, .phy_addr_in(phy_addr),
    .mdc_in(mdc), .mdio_in(mdio_d), .mdio_out, .mdio_oe_out(mdio_oe),
    .an_in(an), .np_tx_out(np_tx), .np_tx_loaded_out(np_ld));
  anp_mdio_host anp_mdio_host_i (.clock_in, .mdio_out,
    .mdio_oe_out(mdio_oe), .mdc_out(mdc), .mdio_to_dev_out(mdio_d));
  initial forever #25 clock_in = ~clock_in;
  function automatic logic [15:0] expect_reg(input logic [4:0] idx);
    case (idx)
      5'h05: return an.lp_base;
      5'h06: return {9'h000, 2'h3, pd_m, an.lp_np_able, 1'h1, pr_m,
        an.lp_an_able};
      5'h07: return tx_m | {4'h0, an.tx_toggle, 11'h000};
      5'h08: return rx_m;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      n_errors++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // a read of index 6 clears the latched flags after returning them
  task automatic rd_reg(input logic [4:0] idx);
    anp_mdio_host_i.frame(2'h2, phy_addr, idx, 16'h0000, rd);
    v = expect_reg(idx);
    if (idx == 5'h06) {pr_m, pd_m} = 2'h0;
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d,
    input logic [4:0] p);
    anp_mdio_host_i.frame(2'h1, p, a, d, rd);
    if (a == 5'h07 && p == phy_addr) tx_m = d & 16'hB7FF;
  endtask
  task automatic page_in(input logic [15:0] pg, input logic f);
    @(posedge clock_in);
    an.rx_page <= pg;
    an.page_rx <= 1'h1;
    an.pd_fault <= f;
    @(posedge clock_in);
    an.page_rx <= 1'h0;
    an.pd_fault <= 1'h0;
    rx_m = pg;
    pr_m = 1'h1;
    pd_m = pd_m | f;
  endtask
  task automatic sweep;
    for (int i = 6; i < 10; i++) begin
      rd_reg(5'(i));
      check(rd, v);
    end
  endtask
  initial begin
    v = $urandom(90);
    repeat (6) @(posedge clock_in);
    rst_n_in <= 1'h1;
    check(np_tx, 16'h2001);
    sweep();
    for (int n = 0; n < 6; n++) begin
      @(posedge clock_in);
      an.lp_base <= 16'($urandom);
      an.lp_np_able <= 1'($urandom);
      an.lp_an_able <= 1'($urandom);
      an.tx_toggle <= 1'($urandom);
      wr_reg(5'h07, 16'($urandom), phy_addr);
      check(np_tx, expect_reg(5'h07));
      page_in(16'($urandom), n[0]);
      rd_reg(5'h06);
      check(rd, v);
      rd_reg(5'h08);
      check(rd, v);
      rd_reg(5'h06);
      check(rd, v);
      rd_reg(5'h05);
      check(rd, v);
    end
    wr_reg(5'h07, 16'hFFFF, phy_addr);
    wr_reg(5'h07, 16'h0000, phy_addr ^ 5'h01);
    wr_reg(5'h06, 16'hFFFF, phy_addr);
    wr_reg(5'h08, 16'hFFFF, phy_addr);
    // opcode 11 is dropped, the transmit page must keep its value
    anp_mdio_host_i.frame(2'h3, phy_addr, 5'h07, 16'h0000, rd);
    sweep();
    page_in(16'h5A5A, 1'h1);
    @(posedge clock_in);
    rst_n_in <= 1'h0;
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'h1;
    tx_m = 16'h2001;
    rx_m = 16'h0000;
    {pr_m, pd_m} = 2'h0;
    sweep();
    summarize();
  end
  initial begin
    repeat (40000) @(posedge clock_in);
    n_errors++;
    summarize();
  end
endmodule // testbench
`default_nettype wire
